/* File: hw/hes_host_error_status_bank.sv */
// Sticky host error status bank with sleep-state masking and write-one-to-clear
`timescale 1ns/100ps
`default_nettype none

module hes_host_error_status_bank (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire logic [7:0]           regAddr,
    input  wire logic                 regWrEn,
    input  wire logic [7:0]           regWrData,
    output logic      [7:0]           regRdData,
    // Sleep state and optional mask enables
    input  wire hes_pkg::hes_sleep_t  sleepState,
    input  wire logic [3:0]           optMaskS1,
    input  wire logic [7:0]           optMaskS3,
    input  wire logic [3:0]           optMaskS45,
    // Error events
    input  wire logic [3:0]           tachOverLimit,
    input  wire logic [3:0]           thermalZoneOutOfRange,
    input  wire logic                 regulatorHotInput_n,
    input  wire logic [3:0]           voltageLowOutOfRange,
    input  wire logic [4:0]           voltageHighOutOfRange,
    input  wire logic                 throttleUserLimitFlag,
    // Status outputs
    output logic                      hostErr,
    output logic [7:0]                fanTachErrorFlags,
    output logic [7:0]                hostZoneRegulatorErrors,
    output logic [7:0]                hostVoltageErrorsLow,
    output logic [7:0]                hostVoltageErrorsHigh
);
    import hes_pkg::*;

    // ==========================================================
    // Next status value for one register
    function automatic logic [7:0] statusNext(
        input logic [7:0] cur,
        input logic [7:0] cond,
        input logic [7:0] mask,
        input logic       wrHit,
        input logic [7:0] wrData,
        input logic [7:0] impl
    );
        logic [7:0] clr;
        clr = wrHit ? (wrData & ~cond) : 8'h00;
        statusNext = ((cur & ~clr) | (cond & ~mask)) & impl;
    endfunction

    // ==========================================================
    // Write strobe aimed at one register offset
    function automatic logic addrHit(
        input logic       wrEn,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        addrHit = wrEn && (addr == ofs);
    endfunction

    // ==========================================================
    // Two optional mask bits picked by the current deep sleep state
    function automatic logic [1:0] optPick(
        input logic       deepS3,
        input logic [1:0] enS3,
        input logic       deepS45,
        input logic [1:0] enS45
    );
        optPick = ({2{deepS3}} & enS3) | ({2{deepS45}} & enS45);
    endfunction

    // ==========================================================
    // Regulator hot pin synchroniser
    // Three stages keep a metastable first stage away from the status logic
    logic [PIN_SYNC_STAGES-1:0] regHotSync_r;
    logic                       regHot_r;
    logic                       regHot_nxt;

    // Active-low pin inverted; level accepted once stages two and three agree
    assign regHot_nxt = (regHotSync_r[1] == regHotSync_r[2]) ? regHotSync_r[2] : regHot_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regHotSync_r <= '0;
            regHot_r     <= 1'b0;
        end else begin
            regHotSync_r <= {regHotSync_r[PIN_SYNC_STAGES-2:0], ~regulatorHotInput_n};
            regHot_r     <= regHot_nxt;
        end
    end

    // ==========================================================
    // Sleep state decode
    wire logic inS1;
    wire logic inS3;
    wire logic inS45;

    assign inS1  = (sleepState == HES_SLEEP_S1);
    assign inS3  = (sleepState == HES_SLEEP_S3);
    assign inS45 = (sleepState == HES_SLEEP_S45);

    wire logic hardMask;
    assign hardMask = inS3 | inS45;

    // ==========================================================
    // Event vectors in register bit order
    wire logic [7:0] fanCond;
    wire logic [7:0] zoneCond;
    wire logic [7:0] vLowCond;
    wire logic [7:0] vHighCond;

    assign fanCond   = {4'h0, tachOverLimit};
    assign zoneCond[3:0]              = thermalZoneOutOfRange;
    assign zoneCond[ZONE_REG_HOT_BIT] = regHot_r;
    assign zoneCond[7:5]              = 3'h0;
    // voltages 1-3 on bits 0-2, voltage 4 on bit 6
    assign vLowCond[2:0]              = voltageLowOutOfRange[2:0];
    assign vLowCond[5:3]              = 3'h0;
    assign vLowCond[VLOW_V4_BIT]      = voltageLowOutOfRange[3];
    assign vLowCond[7]                = 1'b0;
    assign vHighCond[VHIGH_V5_BIT]    = voltageHighOutOfRange[0];
    assign vHighCond[3:1]             = 3'h0;
    assign vHighCond[VHIGH_V16_BIT:VHIGH_V13_BIT] = voltageHighOutOfRange[4:1];

    // ==========================================================
    // Mask vectors, one for a masked bit
    wire logic [7:0] fanMask;
    wire logic [7:0] zoneMask;
    wire logic [7:0] vLowMask;
    wire logic [7:0] vHighMask;
    wire logic [1:0] zoneOptMask;
    wire logic [1:0] vOptMask;

    // optional in S1 and S3, forced in S4/5
    assign fanMask = {4'h0, ({4{inS1}} & optMaskS1) | ({4{inS3}} & optMaskS3[3:0])
                     | {4{inS45}}};

    // zone 1/2 optional in S3 and S4/5
    assign zoneOptMask = optPick(inS3, optMaskS3[5:4], inS45, optMaskS45[1:0]);
    assign zoneMask[1:0]              = zoneOptMask;
    assign zoneMask[3:2]              = 2'h0;
    // regulator hot forced in S3 and S4/5
    assign zoneMask[ZONE_REG_HOT_BIT] = hardMask;
    assign zoneMask[7:5]              = 3'h0;

    // low voltage events forced in S3 and S4/5
    assign vLowMask = {8{hardMask}};

    // voltages 13/14 optional, voltages 5 and 15 forced
    assign vOptMask = optPick(inS3, optMaskS3[7:6], inS45, optMaskS45[3:2]);
    assign vHighMask[VHIGH_V15_BIT-1:VHIGH_V13_BIT] = vOptMask;
    assign vHighMask[VHIGH_V15_BIT]                 = hardMask;
    assign vHighMask[VHIGH_V5_BIT]                  = hardMask;
    assign vHighMask[3:1]                           = 3'h0;
    assign vHighMask[VHIGH_V16_BIT]                 = 1'b0;

    // ==========================================================
    // Write decode
    wire logic wrFan;
    wire logic wrZone;
    wire logic wrVLow;
    wire logic wrVHigh;

    // write hits select the one-to-clear path
    assign wrFan   = addrHit(regWrEn, regAddr, FAN_TACH_ERROR_FLAGS_OFS);
    assign wrZone  = addrHit(regWrEn, regAddr, HOST_ZONE_REGULATOR_ERRORS_OFS);
    assign wrVLow  = addrHit(regWrEn, regAddr, HOST_VOLTAGE_ERRORS_LOW_OFS);
    assign wrVHigh = addrHit(regWrEn, regAddr, HOST_VOLTAGE_ERRORS_HIGH_OFS);

    // ==========================================================
    // Status registers
    logic [7:0] fan_r;
    logic [7:0] zone_r;
    logic [7:0] vLow_r;
    logic [7:0] vHigh_r;
    wire logic [7:0] fan_nxt;
    wire logic [7:0] zone_nxt;
    wire logic [7:0] vLow_nxt;
    wire logic [7:0] vHigh_nxt;

    // sticky set on unmasked event; set wins over clear
    // clear blocked while the condition stands
    assign fan_nxt   = statusNext(fan_r, fanCond, fanMask, wrFan, regWrData, FAN_IMPL_BITS);
    assign zone_nxt  = statusNext(zone_r, zoneCond, zoneMask, wrZone, regWrData,
                                  ZONE_IMPL_BITS);
    assign vLow_nxt  = statusNext(vLow_r, vLowCond, vLowMask, wrVLow, regWrData,
                                  VLOW_IMPL_BITS);
    assign vHigh_nxt = statusNext(vHigh_r, vHighCond, vHighMask, wrVHigh, regWrData,
                                  VHIGH_IMPL_BITS);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fan_r <= STATUS_RESET;
        end else begin
            fan_r <= fan_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            zone_r <= STATUS_RESET;
        end else begin
            zone_r <= zone_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vLow_r <= STATUS_RESET;
        end else begin
            vLow_r <= vLow_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vHigh_r <= STATUS_RESET;
        end else begin
            vHigh_r <= vHigh_nxt;
        end
    end

    // ==========================================================
    // Read mux and summary flag
    // Read data is registered, so it follows regAddr one cycle late
    logic [7:0] rdMux;

    always_comb begin
        case (regAddr)
            FAN_TACH_ERROR_FLAGS_OFS:       rdMux = fan_r;
            HOST_ZONE_REGULATOR_ERRORS_OFS: rdMux = zone_r;
            HOST_VOLTAGE_ERRORS_LOW_OFS:    rdMux = vLow_r;
            HOST_VOLTAGE_ERRORS_HIGH_OFS:   rdMux = vHigh_r;
            default:                        rdMux = READ_UNMAPPED;
        endcase
    end

    wire logic anyStatus;
    wire logic hostErr_nxt;
    // any set bit raises the summary
    assign anyStatus   = (|fan_r) | (|zone_r) | (|vLow_r) | (|vHigh_r);
    // fixed throttle bits have no input here
    assign hostErr_nxt = anyStatus | throttleUserLimitFlag;

    logic [7:0] rdData_r;
    logic       hostErr_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdData_r <= READ_UNMAPPED;
        end else begin
            rdData_r <= rdMux;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hostErr_r <= 1'b0;
        end else begin
            hostErr_r <= hostErr_nxt;
        end
    end

    assign regRdData               = rdData_r;
    assign hostErr                 = hostErr_r;
    assign fanTachErrorFlags       = fan_r;
    assign hostZoneRegulatorErrors = zone_r;
    assign hostVoltageErrorsLow    = vLow_r;
    assign hostVoltageErrorsHigh   = vHigh_r;

endmodule

`default_nettype wire

/* File: hw/hes_pkg.sv */
// Constants shared by the host error status bank
package hes_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] FAN_TACH_ERROR_FLAGS_OFS       = 8'h47;
    localparam logic [7:0] HOST_ZONE_REGULATOR_ERRORS_OFS = 8'h48;
    localparam logic [7:0] HOST_VOLTAGE_ERRORS_LOW_OFS    = 8'h49;
    localparam logic [7:0] HOST_VOLTAGE_ERRORS_HIGH_OFS   = 8'h4a;

    // ==========================================================
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ==========================================================
    // Implemented bit positions of each status register
    localparam logic [7:0] FAN_IMPL_BITS   = 8'h0f;
    localparam logic [7:0] ZONE_IMPL_BITS  = 8'h1f;
    localparam logic [7:0] VLOW_IMPL_BITS  = 8'h47;
    localparam logic [7:0] VHIGH_IMPL_BITS = 8'hf1;

    // ==========================================================
    // Field positions
    localparam int ZONE_REG_HOT_BIT = 4;
    localparam int VLOW_V4_BIT      = 6;
    localparam int VHIGH_V5_BIT     = 0;
    localparam int VHIGH_V13_BIT    = 4;
    localparam int VHIGH_V15_BIT    = 6;
    localparam int VHIGH_V16_BIT    = 7;

    // ==========================================================
    // Sleep state encoding
    typedef enum logic [1:0] {
        HES_SLEEP_S0  = 2'h0,
        HES_SLEEP_S1  = 2'h1,
        HES_SLEEP_S3  = 2'h2,
        HES_SLEEP_S45 = 2'h3
    } hes_sleep_t;

    // ==========================================================
    // Pin synchroniser depth
    localparam int PIN_SYNC_STAGES = 3;

endpackage

/* File: tb/hes_bank_sva.sv */
// Assertion checker for the host error status bank
`timescale 1ns/100ps
`default_nettype none

module hes_bank_sva
    import hes_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    // Sleep state and events
    input wire hes_sleep_t sleepState,
    input wire logic [3:0] thermalZoneOutOfRange,
    input wire logic [3:0] voltageLowOutOfRange,
    input wire logic [4:0] voltageHighOutOfRange,
    input wire logic       throttleUserLimitFlag,
    // Status outputs
    input wire logic       hostErr,
    input wire logic [7:0] fanTachErrorFlags,
    input wire logic [7:0] hostZoneRegulatorErrors,
    input wire logic [7:0] hostVoltageErrorsLow,
    input wire logic [7:0] hostVoltageErrorsHigh
);
    wire logic anySet = |{fanTachErrorFlags, hostZoneRegulatorErrors,
                          hostVoltageErrorsLow, hostVoltageErrorsHigh};
    wire logic deep = sleepState == HES_SLEEP_S3 || sleepState == HES_SLEEP_S45;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Properties
    property p_rsvFan; fanTachErrorFlags[7:4] == 4'h0; endproperty
    property p_rsvZone; hostZoneRegulatorErrors[7:5] == 3'h0; endproperty
    property p_zone3; thermalZoneOutOfRange[2] |=> hostZoneRegulatorErrors[2]; endproperty
    property p_v16; voltageHighOutOfRange[4] |=> hostVoltageErrorsHigh[7]; endproperty
    property p_v15; deep && !hostVoltageErrorsHigh[6] |=> !hostVoltageErrorsHigh[6]; endproperty
    property p_v4;
        sleepState == HES_SLEEP_S0 && voltageLowOutOfRange[3] |=> hostVoltageErrorsLow[6];
    endproperty
    property p_clr;
        regWrEn && regAddr == 8'h49 && regWrData[0] && !voltageLowOutOfRange[0]
            |=> !hostVoltageErrorsLow[0];
    endproperty
    property p_errHi; anySet |=> hostErr; endproperty
    property p_errLo; !anySet && !throttleUserLimitFlag |=> !hostErr; endproperty

    // ==========================================================
    // Assertions
    a_rsvFan:
        assert property (p_rsvFan) else $error("fan reserved bits set");
    a_rsvZone:
        assert property (p_rsvZone) else $error("zone reserved bits set");
    a_zone3:
        assert property (p_zone3) else $error("zone 3 flag missing");
    a_v16:
        assert property (p_v16) else $error("voltage 16 flag missing");
    a_v15:
        assert property (p_v15) else $error("voltage 15 set while masked");
    a_v4:
        assert property (p_v4) else $error("voltage 4 flag missing");
    a_clr:
        assert property (p_clr) else $error("voltage 1 flag not cleared");
    a_errHi:
        assert property (p_errHi) else $error("summary flag missing");
    a_errLo:
        assert property (p_errLo) else $error("summary flag without cause");

    c_clr: cover property (p_clr);
    c_err: cover property ($rose(hostErr));
    c_v15: cover property (deep ##1 !deep);
endmodule

bind hes_host_error_status_bank hes_bank_sva u_sva (
    .sys_clk, .rst_n, .regAddr, .regWrEn, .regWrData, .sleepState,
    .thermalZoneOutOfRange, .voltageLowOutOfRange, .voltageHighOutOfRange,
    .throttleUserLimitFlag, .hostErr, .fanTachErrorFlags,
    .hostZoneRegulatorErrors, .hostVoltageErrorsLow, .hostVoltageErrorsHigh
);

`default_nettype wire

/* File: tb/hes_host_error_status_bank_tb.sv */
// Random self-checking testbench for the host error status bank
`timescale 1ns/100ps
`default_nettype none

module hes_host_error_status_bank_tb;
    import hes_pkg::*;

    logic       sys_clk, rst_n, regWrEn, regHot_n, thr, hostErr, mErr, hotFilt;
    logic [7:0] regAddr, regWrData, regRdData, optMaskS3, mRd, clr;
    logic [3:0] optMaskS1, optMaskS45, tach, zone, vLow;
    logic [4:0] vHigh;
    logic [2:0] hotSync;
    logic [1:0] o2;
    logic [7:0] st [4];
    logic [7:0] ms [4];
    logic [7:0] cnd [4];
    logic [7:0] msk [4];
    hes_sleep_t sleepState;
    int         errorCnt, nTests;
    localparam logic [7:0] IMPL [4] = '{FAN_IMPL_BITS, ZONE_IMPL_BITS,
                                        VLOW_IMPL_BITS, VHIGH_IMPL_BITS};

    hes_host_error_status_bank dut (
        .sys_clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdData,
        .sleepState, .optMaskS1, .optMaskS3, .optMaskS45,
        .tachOverLimit(tach), .thermalZoneOutOfRange(zone),
        .regulatorHotInput_n(regHot_n), .voltageLowOutOfRange(vLow),
        .voltageHighOutOfRange(vHigh), .throttleUserLimitFlag(thr), .hostErr,
        .fanTachErrorFlags(st[0]), .hostZoneRegulatorErrors(st[1]),
        .hostVoltageErrorsLow(st[2]), .hostVoltageErrorsHigh(st[3])
    );

    // ==========================================================
    // Reference model
    wire logic deep = sleepState == HES_SLEEP_S3 || sleepState == HES_SLEEP_S45;
    assign o2 = (sleepState == HES_SLEEP_S3) ? optMaskS3[5:4] : optMaskS45[1:0];
    assign cnd[0] = {4'h0, tach};
    assign cnd[1] = {3'h0, ~hotFilt, zone};
    assign cnd[2] = {1'b0, vLow[3], 3'h0, vLow[2:0]};
    assign cnd[3] = {vHigh[4:1], 3'h0, vHigh[0]};
    assign msk[0] = {4'h0, (sleepState == HES_SLEEP_S1) ? optMaskS1 :
                    (sleepState == HES_SLEEP_S3) ? optMaskS3[3:0] :
                    (sleepState == HES_SLEEP_S45) ? 4'hf : 4'h0};
    assign msk[1] = deep ? {3'h0, 1'b1, 2'h0, o2} : 8'h00;
    assign msk[2] = deep ? 8'hff : 8'h00;
    assign msk[3] = !deep ? 8'h00 : {2'b01, (sleepState == HES_SLEEP_S3) ?
                    optMaskS3[7:6] : optMaskS45[3:2], 4'h1};

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            hotSync <= 3'h7;
            hotFilt <= 1'b1;
        end else begin
            hotSync <= {hotSync[1:0], regHot_n};
            if (hotSync[1] == hotSync[2]) hotFilt <= hotSync[2];
        end
        mErr <= rst_n && ((|{ms[0], ms[1], ms[2], ms[3]}) | thr);
        mRd  <= (rst_n && regAddr >= 8'h47 && regAddr <= 8'h4a) ? ms[regAddr - 8'h47] : 8'h00;
        for (int r = 0; r < 4; r++) begin
            clr = (regWrEn && regAddr == 8'h47 + r) ? regWrData : 8'h00;
            ms[r] <= !rst_n ? 8'h00 :
                     ((ms[r] & ~(clr & ~cnd[r])) | (cnd[r] & ~msk[r])) & IMPL[r];
        end
    end

    // ==========================================================
    // Comparison
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("FAIL %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpRd(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("FAIL %0t read got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("FAIL %0t summary got %b expected %b", $time, got, exp);
        end
    endtask

    always @(negedge sys_clk) if (rst_n) begin
        for (int r = 0; r < 4; r++) cmp8(st[r], ms[r]);
        cmpRd(regRdData, mRd);
        cmp1(hostErr, mErr);
    end

    task automatic tallyAndFinish;
        if (errorCnt == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Stimulus
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        {rst_n, regWrEn, regAddr, regWrData, tach, zone, vLow, vHigh, thr} = '0;
        {optMaskS1, optMaskS3, optMaskS45} = '0;
        {regHot_n, hotFilt, hotSync} = 5'h1f;
        sleepState = HES_SLEEP_S0;
        errorCnt = 0;
        nTests = 0;
        void'($urandom(7));
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 6000; i++) begin
            @(posedge sys_clk);
            #1;
            // every state with fresh optional masks
            if (i % 150 == 0) begin
                sleepState = hes_sleep_t'((i / 150) % 4);
                {optMaskS1, optMaskS3, optMaskS45} = 16'($urandom);
            end
            rst_n = (i != 3000);
            tach = 4'($urandom & $urandom & $urandom);
            zone = 4'($urandom & $urandom & $urandom);
            vLow = 4'($urandom & $urandom & $urandom);
            vHigh = 5'($urandom & $urandom & $urandom);
            thr = ($urandom % 16 == 0);
            if ($urandom % 40 == 0) regHot_n = ~regHot_n;
            // clears to mapped, reserved and unmapped places
            regWrEn = ($urandom % 3 == 0);
            regAddr = 8'h45 + 8'($urandom % 8);
            regWrData = 8'($urandom);
        end
        repeat (4) @(posedge sys_clk);
        tallyAndFinish();
    end
endmodule

`default_nettype wire
